// file: core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model
  import int_ctrl_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire vec_req_t   vec_i,
  input  wire logic [3:0] ack_delay_i,
  input  wire logic       ret_req_i,
  output var  logic       c4_strobe_o,
  output var  logic       instr_end_o,
  output var  logic       vector_ack_o,
  output var  logic       return_o,
  output var  logic [7:0] taken_o,
  output var  logic [7:0] n_taken_o
);
  logic [1:0] phase_q;
  logic [3:0] wait_q;
  logic       ret_pend_q;

  // four clocks per instruction; the boundary is the end of the fourth
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q     <= 2'h0;
      c4_strobe_o <= 1'b0;
      instr_end_o <= 1'b0;
    end else begin
      phase_q     <= phase_q + 2'h1;
      c4_strobe_o <= phase_q == 2'h2;
      instr_end_o <= phase_q == 2'h2;
    end
  end

  // a return can only retire at an instruction boundary
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ret_pend_q <= 1'b0;
      return_o   <= 1'b0;
    end else begin
      ret_pend_q <= (ret_pend_q | ret_req_i) & !(ret_pend_q && phase_q == 2'h2);
      return_o   <= ret_pend_q && phase_q == 2'h2;
    end
  end

  // slow core: ack held back by ack_delay_i cycles, then a one-cycle pulse
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_q       <= 4'h0;
      vector_ack_o <= 1'b0;
      taken_o      <= 8'h00;
      n_taken_o    <= 8'h00;
    end else if (vec_i.req && !vector_ack_o) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == ack_delay_i) begin
        vector_ack_o <= 1'b1;
        taken_o      <= vec_i.vector;
        n_taken_o    <= n_taken_o + 8'h01;
      end
    end else begin
      wait_q       <= 4'h0;
      vector_ack_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: int_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module int_ctrl
  import int_ctrl_pkg::*;
#(
  parameter logic [7:0] PFAIL_VECTOR = 8'h5B
) (
  input  wire logic     clock_i,
  input  wire logic     rst_b_i,
  input  wire sfr_req_t sfr_i,
  output var  logic [7:0] sfr_rdata_o,
  input  wire logic     c4_strobe_i,
  input  wire logic     instr_end_i,
  input  wire logic     return_from_service_i,
  input  wire logic     vector_ack_i,
  output var  vec_req_t vec_o,
  input  wire logic     spi_rx_overrun_i,
  input  wire logic     spi_tx_empty_i,
  input  wire logic     spi_rx_avail_i,
  input  wire logic     spi_type_select_i,
  input  wire logic     pin1_type_select_i,
  input  wire logic     ext_pin0_request_b_i,
  input  wire logic     ext_pin1_request_b_i,
  input  wire logic     ext_pin2_request_i,
  input  wire logic     converter_request_i,
  input  wire logic     timer0_overflow_flag_i,
  input  wire logic     timer1_overflow_flag_i,
  input  wire logic     timer2_overflow_flag_i,
  input  wire logic     timer2_external_flag_i,
  input  wire logic     serial0_tx_flag_i,
  input  wire logic     serial0_rx_flag_i,
  input  wire logic     serial1_tx_flag_i,
  input  wire logic     serial1_rx_flag_i,
  input  wire logic     power_fail_i,
  output var  logic     spi_pending_o,
  output var  logic     pin1_pending_o
);

  logic rst_meta_q, rst_q;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
    first_set = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  logic [7:0] std_en_q;
  logic [6:0] std_pri_q;
  logic [2:0] ext_en_q, ext_pri_q;
  logic       smod_q;
  logic       pin0_pend_q, conv_pend_q, pin2_pend_q;
  logic       spi_pend_q, pin1_pend_q;
  logic       p0_smp_q, p1_smp_q, p2_smp_q, conv_prev_q, spi_prev_b_q;
  logic       ins_lo_q, ins_hi_q, ins_pf_q;
  logic       block_q;
  arb_state_t state_q;
  svc_level_t lvl_q;
  logic [3:0] src_q;

  wire logic wr_en = sfr_i.wr;
  wire logic ack   = (state_q == ST_WAIT_ACK) && vector_ack_i;

  // combined peripheral request, active low
  wire logic spi_req_b = !(spi_rx_overrun_i || spi_tx_empty_i || spi_rx_avail_i);

  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      std_en_q  <= STD_EN_RST;
      std_pri_q <= STD_PRI_RST;
      ext_en_q  <= EXT_RST;
      ext_pri_q <= EXT_RST;
      smod_q    <= 1'b0;
    end else if (wr_en) begin
      case (sfr_i.addr)
        STD_EN_ADDR:   std_en_q  <= sfr_i.wdata;
        STD_PRI_ADDR:  std_pri_q <= sfr_i.wdata[6:0];
        EXT_EN_ADDR:   ext_en_q  <= {sfr_i.wdata[PIN2_ON_BIT], sfr_i.wdata[PIN0_ON_BIT],
                                     sfr_i.wdata[CONV_ON_BIT]};
        EXT_PRI_ADDR:  ext_pri_q <= {sfr_i.wdata[PIN2_ON_BIT], sfr_i.wdata[PIN0_ON_BIT],
                                     sfr_i.wdata[CONV_ON_BIT]};
        EXT_CTRL_ADDR: smod_q    <= sfr_i.wdata[SMOD_BIT];
        default: ;
      endcase
    end
  end

  // pin sampling once per instruction
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      p0_smp_q <= 1'b1;
      p1_smp_q <= 1'b1;
      p2_smp_q <= 1'b0;
    end else if (c4_strobe_i) begin
      p0_smp_q <= ext_pin0_request_b_i;
      p1_smp_q <= ext_pin1_request_b_i;
      p2_smp_q <= ext_pin2_request_i;
    end
  end

  wire logic p0_fall = c4_strobe_i && p0_smp_q && !ext_pin0_request_b_i;
  wire logic p2_rise = c4_strobe_i && !p2_smp_q && ext_pin2_request_i;
  wire logic p1_fall = c4_strobe_i && p1_smp_q && !ext_pin1_request_b_i;
  wire logic conv_rise = converter_request_i && !conv_prev_q;
  wire logic spi_fall  = spi_prev_b_q && !spi_req_b;

  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      conv_prev_q  <= 1'b0;
      spi_prev_b_q <= 1'b1;
    end else begin
      conv_prev_q  <= converter_request_i;
      spi_prev_b_q <= spi_req_b;
    end
  end

  // software-cleared flags; a hardware set beats a clear in the same cycle
  wire logic wr_flag = wr_en && (sfr_i.addr == EXT_FLAG_ADDR);
  wire logic wr_ctrl = wr_en && (sfr_i.addr == EXT_CTRL_ADDR);

  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      pin0_pend_q <= 1'b0;
      conv_pend_q <= 1'b0;
      pin2_pend_q <= 1'b0;
    end else begin
      pin0_pend_q <= p0_fall || (wr_flag ? sfr_i.wdata[PIN0_PEND_BIT] : pin0_pend_q);
      conv_pend_q <= conv_rise || (wr_flag ? sfr_i.wdata[CONV_PEND_BIT] : conv_pend_q);
      pin2_pend_q <= p2_rise || (wr_ctrl ? sfr_i.wdata[PIN2_PEND_BIT] : pin2_pend_q);
    end
  end

  // edge flags clear when their vector is taken; level mode follows the line
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      spi_pend_q  <= 1'b0;
      pin1_pend_q <= 1'b0;
    end else begin
      if (!spi_type_select_i) begin
        spi_pend_q <= !spi_req_b;
      end else begin
        spi_pend_q <= spi_fall || (spi_pend_q && !(ack && src_q == 4'(SRC_SPI)));
      end
      if (!pin1_type_select_i) begin
        if (c4_strobe_i) begin
          pin1_pend_q <= !ext_pin1_request_b_i;
        end
      end else begin
        pin1_pend_q <= p1_fall || (pin1_pend_q && !(ack && src_q == 4'(SRC_P1)));
      end
    end
  end

  logic [NUM_SRC-1:0] pend, enab, level;
  always_comb begin
    pend          = '0;
    pend[SRC_SPI] = spi_pend_q;
    pend[SRC_T0]  = timer0_overflow_flag_i;
    pend[SRC_P1]  = pin1_pend_q;
    pend[SRC_T1]  = timer1_overflow_flag_i;
    pend[SRC_S0]  = serial0_tx_flag_i || serial0_rx_flag_i;
    pend[SRC_T2]  = timer2_overflow_flag_i || timer2_external_flag_i;
    pend[SRC_S1]  = serial1_tx_flag_i || serial1_rx_flag_i;
    pend[SRC_ADC] = conv_pend_q;
    pend[SRC_P0]  = pin0_pend_q;
    pend[SRC_P2]  = pin2_pend_q;
  end
  assign enab  = {ext_en_q, std_en_q[6:0]} & {NUM_SRC{std_en_q[GLOBAL_MASK_BIT]}};
  assign level = {ext_pri_q, std_pri_q};

  wire logic [NUM_SRC-1:0] act    = pend & enab;
  wire logic [NUM_SRC-1:0] act_hi = act & level;
  wire logic               any_hi = |act_hi;
  wire logic [3:0]         win    = any_hi ? first_set(act_hi) : first_set(act);

  logic       take;
  svc_level_t take_lvl;
  always_comb begin
    take     = 1'b0;
    take_lvl = LVL_LOW;
    if (power_fail_i && !ins_pf_q) begin
      take     = 1'b1;
      take_lvl = LVL_PFAIL;
    end else if (any_hi && !ins_hi_q && !ins_pf_q) begin
      take     = 1'b1;
      take_lvl = LVL_HIGH;
    end else if ((|act) && !any_hi && !ins_lo_q && !ins_hi_q && !ins_pf_q) begin
      take     = 1'b1;
      take_lvl = LVL_LOW;
    end
  end

  // an extra instruction runs after a return or an enable/priority write
  wire logic ctl_write = wr_en && (sfr_i.addr == STD_EN_ADDR || sfr_i.addr == STD_PRI_ADDR ||
                                   sfr_i.addr == EXT_EN_ADDR || sfr_i.addr == EXT_PRI_ADDR);
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      block_q <= 1'b0;
    end else if (return_from_service_i || ctl_write) begin
      block_q <= 1'b1;
    end else if (instr_end_i) begin
      block_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= ST_IDLE;
      lvl_q   <= LVL_LOW;
      src_q   <= 4'h0;
      vec_o   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // the boundary that ends a return or a control write is never a service point
          if (instr_end_i && !block_q && !return_from_service_i && !ctl_write && take) begin
            state_q    <= ST_WAIT_ACK;
            lvl_q      <= take_lvl;
            // power fail owns no edge flag, so its ack must not clear one
            src_q      <= (take_lvl == LVL_PFAIL) ? 4'hF : win;
            vec_o.req  <= 1'b1;
            vec_o.vector <= (take_lvl == LVL_PFAIL) ? PFAIL_VECTOR
                                                    : VEC_TABLE[win];
          end
        end
        ST_WAIT_ACK: begin
          if (vector_ack_i) begin
            state_q   <= ST_IDLE;
            vec_o.req <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // in-service markers; a return retires the most recent level
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      ins_lo_q <= 1'b0;
      ins_hi_q <= 1'b0;
      ins_pf_q <= 1'b0;
    end else if (ack) begin
      ins_lo_q <= ins_lo_q || (lvl_q == LVL_LOW);
      ins_hi_q <= ins_hi_q || (lvl_q == LVL_HIGH);
      ins_pf_q <= ins_pf_q || (lvl_q == LVL_PFAIL);
    end else if (return_from_service_i) begin
      if (ins_pf_q) begin
        ins_pf_q <= 1'b0;
      end else if (ins_hi_q) begin
        ins_hi_q <= 1'b0;
      end else begin
        ins_lo_q <= 1'b0;
      end
    end
  end

  logic [7:0] code;
  always_comb begin
    if (spi_rx_overrun_i) begin
      code = CODE_OVERRUN;
    end else if (spi_tx_empty_i) begin
      code = CODE_TX_EMPTY;
    end else if (spi_rx_avail_i) begin
      code = CODE_RX_AVAIL;
    end else begin
      code = CODE_NONE;
    end
  end

  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    case (sfr_i.addr)
      EXT_FLAG_ADDR: begin
        rd = EXT_FLAG_ONES;
        rd[PIN0_PEND_BIT] = pin0_pend_q;
        rd[CONV_PEND_BIT] = conv_pend_q;
      end
      STD_EN_ADDR:  rd = std_en_q;
      STD_PRI_ADDR: rd = STD_PRI_ONES | {1'b0, std_pri_q};
      EXT_CTRL_ADDR: begin
        rd = EXT_CTRL_ONES;
        rd[SMOD_BIT]      = smod_q;
        rd[PIN2_PEND_BIT] = pin2_pend_q;
      end
      SRC_CODE_ADDR: rd = code;
      EXT_EN_ADDR, EXT_PRI_ADDR: begin
        rd = EXT_EN_ONES;
        rd[PIN2_ON_BIT] = (sfr_i.addr == EXT_EN_ADDR) ? ext_en_q[2] : ext_pri_q[2];
        rd[PIN0_ON_BIT] = (sfr_i.addr == EXT_EN_ADDR) ? ext_en_q[1] : ext_pri_q[1];
        rd[CONV_ON_BIT] = (sfr_i.addr == EXT_EN_ADDR) ? ext_en_q[0] : ext_pri_q[0];
      end
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      sfr_rdata_o    <= 8'h00;
      spi_pending_o  <= 1'b0;
      pin1_pending_o <= 1'b0;
    end else begin
      sfr_rdata_o    <= rd;
      spi_pending_o  <= spi_pend_q;
      pin1_pending_o <= pin1_pend_q;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_q);

  property p_vector_taken;
    (state_q == ST_IDLE && instr_end_i && !block_q && !return_from_service_i && !ctl_write &&
     take && take_lvl != LVL_PFAIL)
      |=> vec_o.req && vec_o.vector == VEC_TABLE[$past(win)];
  endproperty
  a_vector_taken: assert property (p_vector_taken) else $error("wrong vector issued");

  property p_mask_all;
    !std_en_q[GLOBAL_MASK_BIT] && !power_fail_i && state_q == ST_IDLE |=> !vec_o.req;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("request while globally masked");

  property p_block_after_return;
    return_from_service_i && !vec_o.req |=> !vec_o.req [*5];
  endproperty
  a_block_after_return: assert property (p_block_after_return)
    else $error("serviced right after return");

  property p_no_preempt_high;
    ins_hi_q && !power_fail_i && state_q == ST_IDLE |=> !vec_o.req;
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("high routine preempted");

  property p_low_blocks_low;
    ins_lo_q && !any_hi && !power_fail_i && state_q == ST_IDLE |=> !vec_o.req;
  endproperty
  a_low_blocks_low: assert property (p_low_blocks_low) else $error("equal level preemption");

  property p_code_none;
    !spi_rx_overrun_i && !spi_tx_empty_i && !spi_rx_avail_i && sfr_i.addr == SRC_CODE_ADDR
      |=> sfr_rdata_o == CODE_NONE;
  endproperty
  a_code_none: assert property (p_code_none) else $error("source code not zero");

  property p_code_overrun;
    spi_rx_overrun_i && sfr_i.addr == SRC_CODE_ADDR |=> sfr_rdata_o == CODE_OVERRUN;
  endproperty
  a_code_overrun: assert property (p_code_overrun) else $error("overrun code wrong");

  property p_pin0_flag;
    p0_fall |=> pin0_pend_q ##1 (pin0_pend_q || $past(wr_flag));
  endproperty
  a_pin0_flag: assert property (p_pin0_flag) else $error("pin0 flag not held");

  property p_conv_flag;
    converter_request_i && !$past(converter_request_i) |=> conv_pend_q;
  endproperty
  a_conv_flag: assert property (p_conv_flag) else $error("converter flag missed");

  property p_ack_marks;
    ack && lvl_q == LVL_HIGH |=> ins_hi_q;
  endproperty
  a_ack_marks: assert property (p_ack_marks) else $error("in-service marker not set");

  c_vector_issue: cover property (state_q == ST_IDLE ##1 vec_o.req ##[1:20] vector_ack_i);
  c_high_preempts_low: cover property (ins_lo_q && ack && lvl_q == LVL_HIGH);
  c_power_fail: cover property (vec_o.req && vec_o.vector == PFAIL_VECTOR);
  c_return: cover property (ins_hi_q ##1 return_from_service_i);

endmodule
`default_nettype wire

// file: int_ctrl_pkg.sv
package int_ctrl_pkg;

  localparam int NUM_SRC = 10;

  // register offsets on the special function register port
  localparam logic [7:0] EXT_FLAG_ADDR = 8'h91;
  localparam logic [7:0] STD_EN_ADDR   = 8'hA8;
  localparam logic [7:0] STD_PRI_ADDR  = 8'hB8;
  localparam logic [7:0] EXT_CTRL_ADDR = 8'hD8;
  localparam logic [7:0] SRC_CODE_ADDR = 8'hE4;
  localparam logic [7:0] EXT_EN_ADDR   = 8'hE8;
  localparam logic [7:0] EXT_PRI_ADDR  = 8'hF8;

  // field positions
  localparam int GLOBAL_MASK_BIT = 7;
  localparam int PIN0_PEND_BIT   = 5;
  localparam int CONV_PEND_BIT   = 4;
  localparam int PIN2_PEND_BIT   = 3;
  localparam int SMOD_BIT        = 7;
  localparam int CONV_ON_BIT     = 0;
  localparam int PIN0_ON_BIT     = 1;
  localparam int PIN2_ON_BIT     = 4;

  // bits that read as constant ones
  localparam logic [7:0] STD_PRI_ONES  = 8'h80;
  localparam logic [7:0] EXT_FLAG_ONES = 8'h08;
  localparam logic [7:0] EXT_CTRL_ONES = 8'h40;
  localparam logic [7:0] EXT_EN_ONES   = 8'hE0;

  // reset values
  localparam logic [7:0] STD_EN_RST  = 8'h00;
  localparam logic [6:0] STD_PRI_RST = 7'h00;
  localparam logic [2:0] EXT_RST     = 3'h0;

  // peripheral source codes
  localparam logic [7:0] CODE_OVERRUN  = 8'h01;
  localparam logic [7:0] CODE_TX_EMPTY = 8'h03;
  localparam logic [7:0] CODE_RX_AVAIL = 8'h05;
  localparam logic [7:0] CODE_NONE     = 8'h00;

  // source indices in natural order, index 0 highest
  localparam int SRC_SPI = 0;
  localparam int SRC_T0  = 1;
  localparam int SRC_P1  = 2;
  localparam int SRC_T1  = 3;
  localparam int SRC_S0  = 4;
  localparam int SRC_T2  = 5;
  localparam int SRC_S1  = 6;
  localparam int SRC_ADC = 7;
  localparam int SRC_P0  = 8;
  localparam int SRC_P2  = 9;

  localparam logic [7:0] VEC_TABLE [NUM_SRC] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
                                                 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h63};

  typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_PFAIL} svc_level_t;
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT_ACK} arb_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic       req;
    logic [7:0] vector;
  } vec_req_t;

endpackage

// file: int_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module int_ctrl_tb
  import int_ctrl_pkg::*;
;
  localparam logic [7:0] PF_VEC = 8'h5B; // arbitrary
  typedef struct packed {
    logic [9:0] srcs;
    logic [7:0] en;
    logic [7:0] een;
    logic [7:0] pri;
    logic [7:0] epri;
    logic [7:0] vec;
  } row_t;
  localparam row_t ROWS [14] = '{
    '{10'h001, 8'h81, 8'h00, 8'h00, 8'h00, 8'h03}, '{10'h002, 8'h82, 8'h00, 8'h00, 8'h00, 8'h0B},
    '{10'h004, 8'h84, 8'h00, 8'h00, 8'h00, 8'h13}, '{10'h008, 8'h88, 8'h00, 8'h00, 8'h00, 8'h1B},
    '{10'h010, 8'h90, 8'h00, 8'h00, 8'h00, 8'h23}, '{10'h020, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h2B},
    '{10'h040, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h3B}, '{10'h080, 8'h80, 8'h01, 8'h00, 8'h00, 8'h43},
    '{10'h100, 8'h80, 8'h02, 8'h00, 8'h00, 8'h4B}, '{10'h200, 8'h80, 8'h10, 8'h00, 8'h00, 8'h63},
    '{10'h042, 8'hC2, 8'h00, 8'h40, 8'h00, 8'h3B}, '{10'h00A, 8'h8A, 8'h00, 8'h0A, 8'h00, 8'h0B},
    '{10'h081, 8'h81, 8'h01, 8'h01, 8'h01, 8'h03}, '{10'h002, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}};
  localparam logic [7:0] RA [8] = '{8'h91, 8'hD8, 8'hA8, 8'hB8, 8'hE8, 8'hF8, 8'hE4, 8'h90};
  localparam logic [7:0] RR [8] = '{8'h08, 8'h40, 8'h00, 8'h80, 8'hE0, 8'hE0, 8'h00, 8'h00};
  localparam logic [7:0] RF [8] = '{8'h38, 8'hC8, 8'hFF, 8'hFF, 8'hF3, 8'hF3, 8'h00, 8'h00};
  localparam logic [7:0] CODES [4] = '{CODE_OVERRUN, CODE_TX_EMPTY, CODE_RX_AVAIL, CODE_NONE};

  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  sfr_req_t   sfr = '0;
  logic [9:0] src = '0;
  logic [2:0] spi = '0;
  logic       alt = 1'b0;
  logic       pf = 1'b0;
  logic       p1e = 1'b0;
  logic       spe = 1'b0;
  logic       ret_req = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [7:0] rdata, taken, n_taken, base;
  logic       c4, iend, ack, retn, p1_pend, spi_pend;
  vec_req_t   vec;
  int         n_fail = 0;
  int         checks = 0;

  always #12.5 clk = !clk;

  int_ctrl #(.PFAIL_VECTOR(PF_VEC)) uut (
    .clock_i(clk), .rst_b_i(rst_b), .sfr_i(sfr), .sfr_rdata_o(rdata), .c4_strobe_i(c4),
    .instr_end_i(iend), .return_from_service_i(retn), .vector_ack_i(ack), .vec_o(vec),
    .spi_rx_overrun_i(src[0] | spi[2]), .spi_tx_empty_i(spi[1]), .spi_rx_avail_i(spi[0]),
    .spi_type_select_i(spe), .pin1_type_select_i(p1e),
    .ext_pin0_request_b_i(!src[8]), .ext_pin1_request_b_i(!src[2]),
    .ext_pin2_request_i(src[9]), .converter_request_i(src[7]),
    .timer0_overflow_flag_i(src[1]), .timer1_overflow_flag_i(src[3]),
    .timer2_overflow_flag_i(src[5] & !alt), .timer2_external_flag_i(src[5] & alt),
    .serial0_tx_flag_i(src[4] & !alt), .serial0_rx_flag_i(src[4] & alt),
    .serial1_tx_flag_i(src[6] & !alt), .serial1_rx_flag_i(src[6] & alt),
    .power_fail_i(pf), .spi_pending_o(spi_pend), .pin1_pending_o(p1_pend));

  core_model core (
    .clock_i(clk), .rst_b_i(rst_b), .vec_i(vec), .ack_delay_i(ack_dly), .ret_req_i(ret_req),
    .c4_strobe_o(c4), .instr_end_o(iend), .vector_ack_o(ack), .return_o(retn),
    .taken_o(taken), .n_taken_o(n_taken));

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    sfr <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk);
    sfr.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    sfr.addr <= a;
    repeat (2) @(posedge clk);
    #1;
    check("register", rdata, exp);
    @(posedge clk);
  endtask

  // 00h stands for no vector taken within the window
  task automatic expect_vec(input logic [7:0] exp);
    for (int k = 0; k < 60 && n_taken === base; k++) @(posedge clk);
    #1;
    check("vector", (n_taken !== base) ? taken : 8'h00, exp);
    base = n_taken;
    @(posedge clk);
  endtask

  task automatic ret();
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    base = n_taken;
    @(negedge clk);
    check("pin1 flag", {7'h00, p1_pend}, 8'h00);
    check("vector request", {7'h00, vec.req}, 8'h00);
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      reg_rd(RA[i], RR[i]);
      reg_wr(RA[i], 8'hFF);
      reg_rd(RA[i], RF[i]);
      reg_wr(RA[i], 8'h00);
    end
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      spi <= 3'b111 >> i;
      reg_rd(SRC_CODE_ADDR, CODES[i]);
      check("spi flag", {7'h00, spi_pend}, {7'h00, 1'(i < 3)});
    end
    spi <= 3'h0;
    $display("source code test done");
    for (int i = 0; i < 14; i++) begin
      reg_wr(STD_EN_ADDR, ROWS[i].en);
      reg_wr(STD_PRI_ADDR, ROWS[i].pri);
      reg_wr(EXT_EN_ADDR, ROWS[i].een);
      reg_wr(EXT_PRI_ADDR, ROWS[i].epri);
      alt <= i[0] ^ i[1];
      src <= ROWS[i].srcs;
      expect_vec(ROWS[i].vec);
      src <= '0;
      reg_wr(EXT_FLAG_ADDR, 8'h00);
      reg_wr(EXT_CTRL_ADDR, 8'h00);
      ret();
    end
    $display("vector table test done");
    // low routine, refused equal level, high preempts, power fail preempts high
    ack_dly <= 4'h5;
    reg_wr(STD_EN_ADDR, 8'h9A);
    reg_wr(STD_PRI_ADDR, 8'h02);
    src <= 10'h008;
    expect_vec(8'h1B);
    src <= 10'h018;
    expect_vec(8'h00);
    src <= 10'h01A;
    expect_vec(8'h0B);
    pf <= 1'b1;
    expect_vec(PF_VEC);
    pf <= 1'b0;
    src <= 10'h010;
    ret();
    ret();
    ret();
    expect_vec(8'h23);
    src <= '0;
    ret();
    $display("preemption test done");
    // short pin pulse must be latched in edge mode
    ack_dly <= 4'h0;
    p1e <= 1'b1;
    reg_wr(STD_EN_ADDR, 8'h04);
    src <= 10'h004;
    repeat (8) @(posedge clk);
    src <= '0;
    @(negedge clk);
    check("pin1 flag", {7'h00, p1_pend}, 8'h01);
    @(posedge clk);
    reg_wr(STD_EN_ADDR, 8'h84);
    expect_vec(8'h13);
    ret();
    // edge mode peripheral request: one vector per falling edge
    spe <= 1'b1;
    reg_wr(STD_EN_ADDR, 8'h81);
    spi <= 3'b001;
    expect_vec(8'h03);
    ret();
    expect_vec(8'h00);
    spi <= 3'h0;
    spe <= 1'b0;
    // flags set by software raise their requests
    reg_wr(STD_EN_ADDR, 8'h80);
    reg_wr(EXT_EN_ADDR, 8'h12);
    reg_wr(EXT_FLAG_ADDR, 8'h20);
    reg_wr(EXT_CTRL_ADDR, 8'h08);
    expect_vec(8'h4B);
    reg_wr(EXT_FLAG_ADDR, 8'h00);
    ret();
    expect_vec(8'h63);
    reg_wr(EXT_CTRL_ADDR, 8'h00);
    ret();
    $display("edge and software flag test done");
    // reset in mid-run clears enables and flags
    reg_wr(STD_EN_ADDR, 8'h7F);
    reg_wr(EXT_FLAG_ADDR, 8'h30);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd(STD_EN_ADDR, 8'h00);
    reg_rd(EXT_FLAG_ADDR, 8'h08);
    @(negedge clk);
    check("vector request", {7'h00, vec.req}, 8'h00);
    @(posedge clk);
    $display("reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
